// *** rtl/dbc_bank_legality.sv ***
// per-bank command legality and state tracking of the memory device
`timescale 1ns/100ps
module dbc_bank_legality
    import dbc_pkg::*;
#(
    parameter logic [CNT_W-1:0] RCD_CYC   = ROW_TO_COLUMN_CYC,
    parameter logic [CNT_W-1:0] RP_CYC    = PRECHARGE_CYC,
    parameter logic [CNT_W-1:0] WR_CYC    = WRITE_RECOVERY_CYC,
    parameter logic [CNT_W-1:0] RFC_CYC   = REFRESH_CYCLE_CYC,
    parameter logic [CNT_W-1:0] MRD_CYC   = MODE_SET_CYC,
    parameter int               BURST_LEN = BURST_LEN_DEF
) (
    input  wire logic                                  clk_sys,
    input  wire logic                                  rst_n,
    input  wire logic                                  clk_link,
    input  wire dbc_cmd_pins_type                      link_cmd,
    output dbc_bank_state_type [NUM_BANKS-1:0]         bank_state,
    output logic [NUM_BANKS-1:0][ADDR_W-1:0]           open_row,
    output dbc_glob_state_type                         glob_state,
    output logic                                       link_err,
    output logic                                       err_pulse,
    output logic                                       all_idle
);

    localparam logic [CNT_W-1:0] BURST_CYC = CNT_W'(BURST_LEN / 2);

    initial begin
        if (!(BURST_LEN == 4 || BURST_LEN == 8)) begin
            $error("burst length must be 4 or 8");
        end
        if (RCD_CYC == CNT_ZERO || RP_CYC == CNT_ZERO ||
            WR_CYC == CNT_ZERO || RFC_CYC == CNT_ZERO ||
            MRD_CYC == CNT_ZERO) begin
            $error("timing counts must be at least one");
        end
    end

    // ****************************************
    // link reset release
    // ****************************************
    logic link_rst_q;
    logic link_rst_n;

    always_ff @(posedge clk_link or negedge rst_n) begin
        if (!rst_n) begin
            link_rst_q <= 1'b0;
            link_rst_n <= 1'b0;
        end else begin
            link_rst_q <= 1'b1;
            link_rst_n <= link_rst_q;
        end
    end

    // ****************************************
    // command decode
    // ****************************************
    logic k_act;
    logic k_rd;
    logic k_wr;
    logic k_pre;
    logic k_close_all_cmd;
    logic k_ref;
    logic k_mrs;
    logic k_extended_mode_set_cmd;
    logic k_bad;
    logic k_quiet;
    logic glob_cmd;
    logic autoclose;
    logic glob_ill;
    logic proto_err;
    logic go;
    logic bank_ill [NUM_BANKS];
    logic [CNT_W-1:0] bank_cnt [NUM_BANKS];
    logic [CNT_W-1:0] glob_cnt;

    always_comb begin
        k_act  = 1'b0;
        k_rd   = 1'b0;
        k_wr   = 1'b0;
        k_pre  = 1'b0;
        k_close_all_cmd = 1'b0;
        k_ref  = 1'b0;
        k_mrs  = 1'b0;
        k_extended_mode_set_cmd = 1'b0;
        k_bad  = 1'b0;
        if (!link_cmd.cs_n) begin
            case ({link_cmd.ras_n, link_cmd.cas_n, link_cmd.we_n})
                3'h3: k_act = 1'b1;
                3'h5: k_rd = 1'b1;
                3'h4: k_wr = 1'b1;
                3'h2: begin
                    k_close_all_cmd = link_cmd.addr[AUTOCLOSE_BIT];
                    k_pre  = !link_cmd.addr[AUTOCLOSE_BIT];
                end
                3'h1: k_ref = 1'b1;
                3'h0: begin
                    k_mrs  = (link_cmd.ba == 3'h0);
                    k_extended_mode_set_cmd = (link_cmd.ba != 3'h0) && !link_cmd.ba[2];
                    k_bad  = link_cmd.ba[2];
                end
                default: k_bad = 1'b0;
            endcase
        end
    end

    assign autoclose = link_cmd.addr[AUTOCLOSE_BIT];
    assign glob_cmd  = k_ref || k_mrs || k_extended_mode_set_cmd;
    assign k_quiet   = !(k_act || k_rd || k_wr || k_pre || k_close_all_cmd ||
                         glob_cmd || k_bad);
    // only idle commands while refresh or mode access runs
    assign glob_ill  = k_bad || ((glob_state != G_NORMAL) && !k_quiet);

    always_comb begin
        proto_err = glob_ill;
        for (int b = 0; b < NUM_BANKS; b++) begin
            proto_err = proto_err || bank_ill[b];
        end
    end

    // an illegal command changes no state
    assign go = !proto_err;

    // ****************************************
    // per-bank state machines
    // ****************************************
    for (genvar i = 0; i < NUM_BANKS; i++) begin : g_bank
        logic                hit;
        dbc_bank_state_type  next_state;
        logic [CNT_W-1:0]    next_cnt;

        assign hit = (link_cmd.ba == BA_W'(i));

        always_comb begin
            case (bank_state[i])
                B_IDLE:
                    bank_ill[i] = hit && (k_rd || k_wr);
                B_ACTIVATING:
                    bank_ill[i] = (hit && (k_act || k_rd || k_wr || k_pre))
                                  || k_close_all_cmd || glob_cmd;
                B_ACTIVE:
                    bank_ill[i] = (hit && k_act) || glob_cmd;
                B_READ:
                    bank_ill[i] = (hit && (k_wr || k_act || k_pre))
                                  || k_close_all_cmd || glob_cmd;
                B_WRITE:
                    bank_ill[i] = (hit && (k_rd || k_act || k_pre))
                                  || k_close_all_cmd || glob_cmd;
                B_WREC:
                    bank_ill[i] = (hit && (k_rd || k_act || k_pre))
                                  || k_close_all_cmd || glob_cmd;
                B_PRECHARGE:
                    bank_ill[i] = (hit && (k_rd || k_wr || k_act))
                                  || glob_cmd;
                default:
                    bank_ill[i] = (hit && (k_rd || k_wr || k_act || k_pre))
                                  || k_close_all_cmd || glob_cmd;
            endcase
        end

        always_comb begin
            next_state = bank_state[i];
            next_cnt   = (bank_cnt[i] != CNT_ZERO) ?
                         bank_cnt[i] - CNT_ONE : CNT_ZERO;
            case (bank_state[i])
                B_IDLE: begin
                    if (go && hit && k_act) begin
                        next_state = B_ACTIVATING;
                        next_cnt   = RCD_CYC;
                    end
                end
                B_ACTIVATING: begin
                    if (bank_cnt[i] == CNT_ONE) begin
                        next_state = B_ACTIVE;
                    end
                end
                B_ACTIVE: begin
                    if (go && hit && k_rd) begin
                        next_state = autoclose ? B_READ_AC : B_READ;
                        next_cnt   = BURST_CYC;
                    end else if (go && hit && k_wr) begin
                        next_state = autoclose ? B_WRITE_AC : B_WRITE;
                        next_cnt   = BURST_CYC;
                    end else if (go && ((hit && k_pre) || k_close_all_cmd)) begin
                        next_state = B_PRECHARGE;
                        next_cnt   = RP_CYC;
                    end
                end
                B_READ: begin
                    if (go && hit && k_rd) begin
                        next_state = autoclose ? B_READ_AC : B_READ;
                        next_cnt   = BURST_CYC;
                    end else if (bank_cnt[i] == CNT_ONE) begin
                        next_state = B_ACTIVE;
                    end
                end
                B_WRITE: begin
                    if (go && hit && k_wr) begin
                        next_state = autoclose ? B_WRITE_AC : B_WRITE;
                        next_cnt   = BURST_CYC;
                    end else if (bank_cnt[i] == CNT_ONE) begin
                        next_state = B_WREC;
                        next_cnt   = WR_CYC;
                    end
                end
                B_READ_AC: begin
                    if (bank_cnt[i] == CNT_ONE) begin
                        next_state = B_PRECHARGE;
                        next_cnt   = RP_CYC;
                    end
                end
                B_WRITE_AC: begin
                    if (bank_cnt[i] == CNT_ONE) begin
                        next_state = B_WREC_AC;
                        next_cnt   = WR_CYC;
                    end
                end
                B_WREC: begin
                    if (go && hit && k_wr) begin
                        next_state = autoclose ? B_WRITE_AC : B_WRITE;
                        next_cnt   = BURST_CYC;
                    end else if (bank_cnt[i] == CNT_ONE) begin
                        next_state = B_ACTIVE;
                    end
                end
                B_WREC_AC: begin
                    if (bank_cnt[i] == CNT_ONE) begin
                        next_state = B_PRECHARGE;
                        next_cnt   = RP_CYC;
                    end
                end
                B_PRECHARGE: begin
                    if (go && ((hit && k_pre) || k_close_all_cmd)) begin
                        next_cnt = RP_CYC;
                    end else if (bank_cnt[i] == CNT_ONE) begin
                        next_state = B_IDLE;
                    end
                end
                default: begin
                    next_state = B_IDLE;
                    next_cnt   = CNT_ZERO;
                end
            endcase
        end

        always_ff @(posedge clk_link or negedge link_rst_n) begin
            if (!link_rst_n) begin
                bank_state[i] <= B_IDLE;
                bank_cnt[i]   <= CNT_ZERO;
            end else begin
                bank_state[i] <= next_state;
                bank_cnt[i]   <= next_cnt;
            end
        end

        always_ff @(posedge clk_link or negedge link_rst_n) begin
            if (!link_rst_n) begin
                open_row[i] <= '0;
            end else if (go && hit && k_act && bank_state[i] == B_IDLE) begin
                open_row[i] <= link_cmd.addr;
            end
        end

        AST_ROW_OPEN: assert property (@(posedge clk_link)
            disable iff (!link_rst_n)
            (bank_state[i] == B_IDLE && hit && k_act && go)
            |=> (bank_state[i] == B_ACTIVATING)
                ##(RCD_CYC) (bank_state[i] == B_ACTIVE))
            else $error("row open did not activate bank");
        AST_READ_BEGIN: assert property (@(posedge clk_link)
            disable iff (!link_rst_n)
            (bank_state[i] == B_ACTIVE && hit && k_rd && go)
            |=> ($past(autoclose) && bank_state[i] == B_READ_AC) ||
                (!$past(autoclose) && bank_state[i] == B_READ))
            else $error("read did not begin burst");
        AST_WRITE_BEGIN: assert property (@(posedge clk_link)
            disable iff (!link_rst_n)
            (bank_state[i] == B_ACTIVE && hit && k_wr && go && !autoclose)
            |=> (bank_state[i] == B_WRITE))
            else $error("write did not begin burst");
        AST_CLOSE: assert property (@(posedge clk_link)
            disable iff (!link_rst_n)
            (bank_state[i] == B_ACTIVE && ((hit && k_pre) || k_close_all_cmd) && go)
            |=> (bank_state[i] == B_PRECHARGE) && (bank_cnt[i] == RP_CYC))
            else $error("close did not start precharge");
        AST_READ_END: assert property (@(posedge clk_link)
            disable iff (!link_rst_n)
            (bank_state[i] == B_READ && bank_cnt[i] == CNT_ONE
             && !(hit && k_rd && go))
            |=> (bank_state[i] == B_ACTIVE))
            else $error("read burst did not return to active");
        AST_WRITE_END: assert property (@(posedge clk_link)
            disable iff (!link_rst_n)
            (bank_state[i] == B_WRITE && bank_cnt[i] == CNT_ONE
             && !(hit && k_wr && go))
            |=> (bank_state[i] == B_WREC) && (bank_cnt[i] == WR_CYC))
            else $error("write burst did not enter recovery");
        AST_ILLEGAL_HOLD: assert property (@(posedge clk_link)
            disable iff (!link_rst_n)
            (proto_err && bank_state[i] == B_IDLE)
            |=> (bank_state[i] == B_IDLE) && link_err)
            else $error("illegal command changed idle bank");
        AST_AUTOCLOSE: assert property (@(posedge clk_link)
            disable iff (!link_rst_n)
            (bank_state[i] == B_WREC_AC && bank_cnt[i] == CNT_ONE)
            |=> (bank_state[i] == B_PRECHARGE))
            else $error("write recovery did not precharge");
    end

    // ****************************************
    // refresh and mode access
    // ****************************************
    always_ff @(posedge clk_link or negedge link_rst_n) begin
        if (!link_rst_n) begin
            glob_state <= G_NORMAL;
            glob_cnt   <= CNT_ZERO;
        end else begin
            case (glob_state)
                G_NORMAL: begin
                    if (go && k_ref) begin
                        glob_state <= G_REFRESH;
                        glob_cnt   <= RFC_CYC;
                    end else if (go && k_mrs) begin
                        glob_state <= G_MODE;
                        glob_cnt   <= MRD_CYC;
                    end else if (go && k_extended_mode_set_cmd) begin
                        glob_state <= G_EXTMODE;
                        glob_cnt   <= MRD_CYC;
                    end
                end
                default: begin
                    glob_cnt <= glob_cnt - CNT_ONE;
                    if (glob_cnt == CNT_ONE) begin
                        glob_state <= G_NORMAL;
                    end
                end
            endcase
        end
    end

    AST_MODE_ENTRY: assert property (@(posedge clk_link)
        disable iff (!link_rst_n)
        (glob_state == G_NORMAL && k_mrs && go)
        |=> (glob_state == G_MODE) && (glob_cnt == MRD_CYC))
        else $error("mode set did not enter mode access");
    AST_EXTMODE_ENTRY: assert property (@(posedge clk_link)
        disable iff (!link_rst_n)
        (glob_state == G_NORMAL && k_extended_mode_set_cmd && go)
        |=> (glob_state == G_EXTMODE))
        else $error("extended mode set did not enter access");
    AST_REFRESH_END: assert property (@(posedge clk_link)
        disable iff (!link_rst_n)
        (glob_state == G_REFRESH && glob_cnt == CNT_ONE)
        |=> (glob_state == G_NORMAL))
        else $error("refresh did not return to idle");

    // ****************************************
    // error flag and crossing to system clock
    // ****************************************
    logic err_tgl;
    logic idle_now;
    logic idle_q;
    logic err_s1;
    logic err_s2;
    logic err_s3;
    logic idle_s1;

    always_comb begin
        idle_now = (glob_state == G_NORMAL);
        for (int b = 0; b < NUM_BANKS; b++) begin
            idle_now = idle_now && (bank_state[b] == B_IDLE);
        end
    end

    always_ff @(posedge clk_link or negedge link_rst_n) begin
        if (!link_rst_n) begin
            link_err <= 1'b0;
            err_tgl  <= 1'b0;
            idle_q   <= 1'b1;
        end else begin
            link_err <= proto_err;
            err_tgl  <= err_tgl ^ proto_err;
            // registered so the crossing never sees decode glitches
            idle_q   <= idle_now;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            err_s1    <= 1'b0;
            err_s2    <= 1'b0;
            err_s3    <= 1'b0;
            err_pulse <= 1'b0;
            idle_s1   <= 1'b0;
            all_idle  <= 1'b0;
        end else begin
            err_s1    <= err_tgl;
            err_s2    <= err_s1;
            err_s3    <= err_s2;
            err_pulse <= err_s2 ^ err_s3;
            idle_s1   <= idle_q;
            all_idle  <= idle_s1;
        end
    end

endmodule : dbc_bank_legality

// *** shared/dbc_pkg.sv ***
// shared constants and types of the bank command legality block
package dbc_pkg;

    // ****************************************
    // geometry
    // ****************************************
    localparam int NUM_BANKS     = 8;
    localparam int BA_W          = 3;
    localparam int ADDR_W        = 14;
    localparam int AUTOCLOSE_BIT = 10;
    localparam int CNT_W         = 8;

    // ****************************************
    // timing counts in link clock cycles
    // ****************************************
    localparam logic [CNT_W-1:0] ROW_TO_COLUMN_CYC  = 8'h05;
    localparam logic [CNT_W-1:0] PRECHARGE_CYC      = 8'h05;
    localparam logic [CNT_W-1:0] WRITE_RECOVERY_CYC = 8'h06;
    localparam logic [CNT_W-1:0] REFRESH_CYCLE_CYC  = 8'h34;
    localparam logic [CNT_W-1:0] MODE_SET_CYC       = 8'h02;
    localparam int               BURST_LEN_DEF      = 4;
    localparam logic [CNT_W-1:0] CNT_ONE            = 8'h01;
    localparam logic [CNT_W-1:0] CNT_ZERO           = 8'h00;

    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic              cs_n;
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic [BA_W-1:0]   ba;
        logic [ADDR_W-1:0] addr;
    } dbc_cmd_pins_type;

    typedef enum logic [3:0] {
        B_IDLE      = 4'h0,
        B_ACTIVATING= 4'h1,
        B_ACTIVE    = 4'h2,
        B_READ      = 4'h3,
        B_WRITE     = 4'h4,
        B_READ_AC   = 4'h5,
        B_WRITE_AC  = 4'h6,
        B_WREC      = 4'h7,
        B_WREC_AC   = 4'h8,
        B_PRECHARGE = 4'h9
    } dbc_bank_state_type;

    typedef enum logic [1:0] {
        G_NORMAL  = 2'h0,
        G_REFRESH = 2'h1,
        G_MODE    = 2'h2,
        G_EXTMODE = 2'h3
    } dbc_glob_state_type;

endpackage : dbc_pkg

// *** verif/dbc_ctrl_model.sv ***
// memory controller model driving the command pins
`timescale 1ns/100ps
module dbc_ctrl_model
    import dbc_pkg::*;
(
    input  wire logic       clk_link,
    output dbc_cmd_pins_type link_cmd
);
    // ******
    // command drive
    // ******
    dbc_cmd_pins_type next_cmd;
    logic             req = 1'b0;

    initial link_cmd = '1;

    // unselected pins toggle so no stale value looks valid
    always @(negedge clk_link) begin
        if (req) begin
            link_cmd <= next_cmd;
            req      <= 1'b0;
        end else begin
            link_cmd <= {1'b1, ~link_cmd[19:0]};
        end
    end

    // one command per call; callers pick legal or deliberately illegal commands
    task automatic issue(input logic [2:0]  op,
                         input logic [2:0]  ba,
                         input logic [13:0] a);
        @(posedge clk_link);
        #1;
        next_cmd = {1'b0, op, ba, a};
        req      = 1'b1;
        @(negedge clk_link);
        @(negedge clk_link);
    endtask : issue
endmodule : dbc_ctrl_model

// *** verif/test_dbc_bank_legality.sv ***
// self-checking bench of the bank command legality block
`timescale 1ns/100ps
module test_dbc_bank_legality
    import dbc_pkg::*;
;
    localparam logic [2:0] row_open_cmd = 3'h3;
    localparam logic [2:0] read_cmd     = 3'h5;
    localparam logic [2:0] write_cmd    = 3'h4;
    localparam logic [2:0] close_cmd    = 3'h2;
    localparam logic [2:0] refresh_cmd  = 3'h1;
    localparam logic [2:0] mode_set_cmd = 3'h0;
    localparam logic [7:0] rcd          = 8'h03;
    localparam logic [7:0] rp           = 8'h02;
    localparam logic [7:0] wr           = 8'h03;
    localparam logic [7:0] rfc          = 8'h04;
    localparam logic [7:0] mrd          = 8'h02;
    localparam int         bl2          = 4;

    logic                                  clk_sys;
    logic                                  clk_link;
    logic                                  rst_n;
    dbc_cmd_pins_type                      link_cmd;
    dbc_bank_state_type [NUM_BANKS-1:0]    bank_state;
    logic [NUM_BANKS-1:0][ADDR_W-1:0]      open_row;
    dbc_glob_state_type                    glob_state;
    logic                                  link_err;
    logic                                  err_pulse;
    logic                                  all_idle;
    int n_errors = 0;
    int checks   = 0;
    int n_bad    = 0;
    int n_pulse  = 0;

    dbc_bank_legality #(.RCD_CYC(rcd), .RP_CYC(rp), .WR_CYC(wr),
        .RFC_CYC(rfc), .MRD_CYC(mrd), .BURST_LEN(8)) dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .clk_link(clk_link),
        .link_cmd(link_cmd), .bank_state(bank_state),
        .open_row(open_row), .glob_state(glob_state),
        .link_err(link_err), .err_pulse(err_pulse),
        .all_idle(all_idle));

    dbc_ctrl_model ctrl (.clk_link(clk_link), .link_cmd(link_cmd));

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        clk_link = 1'b0;
        #1.3;
        forever #6 clk_link = ~clk_link;
    end
    always @(negedge clk_sys) begin
        if (err_pulse === 1'b1) n_pulse++;
    end

    // ******
    // helpers
    // ******
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic cmd(input logic [2:0] op, input logic [2:0] b,
                       input logic [13:0] a);
        ctrl.issue(op, b, a);
        chk(link_err, 1'b0);
    endtask : cmd

    // refused command: flagged, nothing moves
    task automatic bad(input logic [2:0] op, input logic [2:0] b,
                       input logic [13:0] a);
        logic [31:0] s;
        logic [1:0]  g;
        s = bank_state;
        g = glob_state;
        ctrl.issue(op, b, a);
        n_bad++;
        chk(link_err, 1'b1);
        chk(bank_state, s);
        chk(glob_state, g);
    endtask : bad

    task automatic walk(input logic [2:0] b, input dbc_bank_state_type s1,
                        input int n, input dbc_bank_state_type s2);
        chk(bank_state[b], s1);
        repeat (n - 1) @(negedge clk_link);
        chk(bank_state[b], s1);
        @(negedge clk_link);
        chk(bank_state[b], s2);
    endtask : walk

    // ******
    // scenarios
    // ******
    task automatic s_open(input logic [2:0] b, input logic [13:0] row);
        cmd(row_open_cmd, b, row);
        chk(open_row[b], row);
        walk(b, B_ACTIVATING, rcd, B_ACTIVE);
    endtask : s_open

    task automatic s_read(input logic [2:0] b);
        bad(row_open_cmd, b, 14'h0000);
        bad(refresh_cmd, b, 14'h0000);
        chk(all_idle, 1'b0);
        cmd(read_cmd, b, 14'h0010);
        cmd(read_cmd, b, 14'h0020);
        walk(b, B_READ, bl2, B_ACTIVE);
        cmd(read_cmd, b, 14'h0030);
        bad(write_cmd, b, 14'h0000);
        walk(b, B_READ, 2, B_ACTIVE);
    endtask : s_read

    task automatic s_write(input logic [2:0] b);
        cmd(write_cmd, b, 14'h0000);
        cmd(write_cmd, b, 14'h0004);
        walk(b, B_WRITE, bl2, B_WREC);
        cmd(write_cmd, b, 14'h0008);
        walk(b, B_WRITE, bl2, B_WREC);
        walk(b, B_WREC, wr, B_ACTIVE);
        cmd(close_cmd, b, 14'h0000);
        cmd(close_cmd, b, 14'h0000);
        walk(b, B_PRECHARGE, rp, B_IDLE);
    endtask : s_write

    task automatic s_autoclose(input logic [2:0] b);
        s_open(b, 14'h2001);
        cmd(write_cmd, b, 14'h0400);
        walk(b, B_WRITE_AC, bl2, B_WREC_AC);
        walk(b, B_WREC_AC, wr, B_PRECHARGE);
        walk(b, B_PRECHARGE, rp, B_IDLE);
        s_open(b, 14'h3FFF);
        cmd(read_cmd, b, 14'h0400);
        walk(b, B_READ_AC, bl2, B_PRECHARGE);
        walk(b, B_PRECHARGE, rp, B_IDLE);
    endtask : s_autoclose

    task automatic s_close_all;
        s_open(3'h0, 14'h0001);
        s_open(3'h7, 14'h2000);
        bad(mode_set_cmd, 3'h0, 14'h0000);
        cmd(close_cmd, 3'h3, 14'h0400);
        chk(bank_state[7], B_PRECHARGE);
        walk(3'h0, B_PRECHARGE, rp, B_IDLE);
        chk(bank_state[7], B_IDLE);
    endtask : s_close_all

    task automatic s_global;
        cmd(refresh_cmd, 3'h0, 14'h0000);
        chk(glob_state, G_REFRESH);
        bad(row_open_cmd, 3'h1, 14'h0000);
        @(negedge clk_link);
        chk(glob_state, G_REFRESH);
        @(negedge clk_link);
        chk(glob_state, G_NORMAL);
        for (int i = 0; i < 4; i++) begin
            cmd(mode_set_cmd, 3'(i), 14'h0000);
            chk(glob_state, (i == 0) ? G_MODE : G_EXTMODE);
            repeat (mrd) @(negedge clk_link);
            chk(glob_state, G_NORMAL);
        end
        bad(mode_set_cmd, 3'h4, 14'h0000);
    endtask : s_global

    task automatic tally_and_finish;
        if (n_errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        #50000;
        n_errors++;
        tally_and_finish();
    end

    initial begin
        rst_n = 1'b0;
        repeat (3) @(posedge clk_link);
        @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (4) @(negedge clk_link);
        chk(all_idle, 1'b1);
        s_open(3'h2, 14'h1ABC);
        s_read(3'h2);
        s_write(3'h2);
        s_autoclose(3'h5);
        s_close_all();
        s_global();
        repeat (10) @(posedge clk_sys);
        chk(n_pulse, n_bad);
        chk(all_idle, 1'b1);
        tally_and_finish();
    end
endmodule : test_dbc_bank_legality
